// ==== pcf_pkg.sv ====
package pcf_pkg;

	// Byte addresses of the configuration registers on the register port.
	localparam logic [7:0] PCF_ADDR_LED_DRIVE = 8'h06;
	localparam logic [7:0] PCF_ADDR_GAIN = 8'h07;
	localparam logic [7:0] PCF_ADDR_PULSE = 8'h08;
	localparam logic [7:0] PCF_ADDR_TIME = 8'h09;
	localparam logic [7:0] PCF_ADDR_PERSIST = 8'h0B;
	localparam logic [7:0] PCF_ADDR_LLO_L = 8'h0C;
	localparam logic [7:0] PCF_ADDR_LLO_H = 8'h0D;
	localparam logic [7:0] PCF_ADDR_LHI_L = 8'h0E;
	localparam logic [7:0] PCF_ADDR_LHI_H = 8'h0F;
	localparam logic [7:0] PCF_ADDR_PLO_L = 8'h10;
	localparam logic [7:0] PCF_ADDR_PLO_H = 8'h11;
	localparam logic [7:0] PCF_ADDR_PHI_L = 8'h12;
	localparam logic [7:0] PCF_ADDR_PHI_H = 8'h13;
	localparam logic [7:0] PCF_ADDR_OFF_L = 8'h14;
	localparam logic [7:0] PCF_ADDR_OFF_H = 8'h15;

	// Reset values.
	localparam logic [7:0] PCF_LED_DRIVE_RST = 8'h00;
	localparam logic [1:0] PCF_GAIN_RST = 2'h0;
	localparam logic [7:0] PCF_PULSE_RST = 8'h00;
	localparam logic [3:0] PCF_TIME_RST = 4'h0;
	localparam logic [7:0] PCF_PERSIST_RST = 8'h11;
	localparam logic [15:0] PCF_THR_LO_RST = 16'h0000;
	localparam logic [15:0] PCF_THR_HI_RST = 16'hFFFF;
	localparam logic [15:0] PCF_OFFSET_RST = 16'h0000;
	localparam logic [7:0] PCF_READ_ZERO = 8'h00;

	// Padding that reads back as zero above the narrow fields.
	localparam logic [5:0] PCF_GAIN_PAD = 6'h00;
	localparam logic [3:0] PCF_TIME_PAD = 4'h0;
	// Low byte of every saturation limit; the resolution code sits above it.
	localparam logic [7:0] PCF_SAT_LOW_BYTE = 8'hFF;
	localparam logic [3:0] PCF_SAT_PAD = 4'h0;

	// Timing figures and their cycle counts at the 100 MHz clock.
	localparam real PCF_CLK_PERIOD_NS = 10.0;
	localparam real PCF_NS_PER_US = 1.0e3;
	localparam real PCF_NS_PER_MS = 1.0e6;
	localparam real PCF_PULSE_UNIT_US = 13.675;
	localparam real PCF_TPS_BASE_MS = 3.051;
	localparam real PCF_TPS_PULSE_MS = 0.01;
	localparam real PCF_TPS_WIDTH_MS = 0.01368;
	localparam real PCF_TPS_RES_MS = 0.51;
	localparam int unsigned PCF_TPS_SCALE = 16;
	localparam int unsigned PCF_PULSE_UNIT_CYC =
		int'($floor(PCF_PULSE_UNIT_US * PCF_NS_PER_US / PCF_CLK_PERIOD_NS));
	localparam int unsigned PCF_TPS_BASE_CYC = int'(PCF_TPS_BASE_MS * PCF_NS_PER_MS / PCF_CLK_PERIOD_NS);
	localparam int unsigned PCF_TPS_PULSE_CYC = int'(PCF_TPS_PULSE_MS * PCF_NS_PER_MS / PCF_CLK_PERIOD_NS);
	localparam int unsigned PCF_TPS_WIDTH_CYC = int'(PCF_TPS_WIDTH_MS * PCF_NS_PER_MS / PCF_CLK_PERIOD_NS);
	localparam int unsigned PCF_TPS_RES_CYC = int'(PCF_TPS_RES_MS * PCF_NS_PER_MS / PCF_CLK_PERIOD_NS);

	// Measurement cycle phases.
	typedef enum logic [1:0] {
		PCF_PH_IDLE = 2'b00,
		PCF_PH_LIGHT = 2'b01,
		PCF_PH_PROX = 2'b10,
		PCF_PH_WAIT = 2'b11
	} pcf_phase_e;

	// LED control byte layout.
	typedef struct packed {
		logic [1:0] led_current_select;
		logic [5:0] led_pulse_width;
	} pcf_led_drive_s;

	// Persistence byte layout.
	typedef struct packed {
		logic [3:0] proximity_persistence;
		logic [3:0] light_persistence;
	} pcf_persist_cfg_s;

	// State of one persistence counter.
	typedef struct packed {
		logic [3:0] count;
		logic fire;
	} pcf_pcount_s;

	// Whole state of the configuration and threshold block.
	typedef struct packed {
		pcf_led_drive_s led_drive;
		logic [1:0] proximity_gain_code;
		logic [7:0] led_pulse_number;
		logic [3:0] proximity_resolution;
		pcf_persist_cfg_s persist;
		logic [15:0] light_lo;
		logic [15:0] light_hi;
		logic [15:0] prox_lo;
		logic [15:0] prox_hi;
		logic [15:0] crosstalk_correction;
		logic [7:0] rdata;
		pcf_phase_e phase;
		logic [31:0] timer;
		logic [16:0] pulse_timer;
		logic [8:0] pulses_left;
		logic led_on;
		logic [15:0] proximity_result;
		logic [15:0] infrared_result;
		logic result_valid;
		logic light_eval;
		logic light_hit;
		logic prox_eval;
		logic prox_hit;
	} pcf_state_s;

endpackage

// ==== pcf_persist.sv ====
`timescale 1ns/100ps
// Counts consecutive qualifying conversions and fires once the persistence
// setting is reached; a setting of zero fires on every conversion.
module pcf_persist
	import pcf_pkg::*;
(
	input wire logic mclk, // System clock.
	input wire logic rst_b, // Synchronous reset, active low.
	input wire logic sample, // One-cycle pulse: a conversion was evaluated.
	input wire logic hit, // The conversion met the interrupt condition.
	input wire logic [3:0] setting, // Persistence setting.
	output logic fire // One-cycle interrupt event.
);

	pcf_pcount_s st; // Registered state.
	pcf_pcount_s next_st; // Next state.

	// Count hits, clear on a miss, fire and restart on reaching the setting.
	always_comb begin
		next_st = st;
		next_st.fire = 1'b0;
		if (sample) begin
			if (setting == 4'h0) begin
				// Thresholds are ignored: every conversion counts as an event.
				next_st.fire = 1'b1; // [RL8] [RL9]
				next_st.count = 4'h0;
			end else if (hit) begin
				if (st.count + 4'h1 == setting) begin
					next_st.fire = 1'b1; // [RL13]
					next_st.count = 4'h0;
				end else begin
					next_st.count = st.count + 4'h1; // [RL13]
				end
			end else begin
				next_st.count = 4'h0; // [RL13]
			end
		end
	end

	// Register the state.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign fire = st.fire;

	property p_every_conv;
		@(posedge mclk) disable iff (!rst_b)
		sample && setting == 4'h0 |=> fire;
	endproperty
	a_every_conv: assert property (p_every_conv) else $error("zero setting did not fire"); // [RL8]

	property p_miss_clears;
		@(posedge mclk) disable iff (!rst_b)
		sample && !hit && setting != 4'h0 |=> !fire && st.count == 4'h0;
	endproperty
	a_miss_clears: assert property (p_miss_clears) else $error("miss did not clear count"); // [RL13]

	property p_reach_fires;
		@(posedge mclk) disable iff (!rst_b)
		sample && hit && setting != 4'h0 && st.count + 4'h1 == setting |=> fire && st.count == 4'h0;
	endproperty
	a_reach_fires: assert property (p_reach_fires) else $error("count reached setting, no event"); // [RL9]

endmodule

// ==== pcf_prox_cfg.sv ====
`timescale 1ns/100ps
// Function
// (RL1) LED peak current from two-bit select
// (RL2) Pulse lasts field plus one 13.675 us units
// (RL3) Gain code two bits, upper bits read zero
// (RL4) Field plus one LED pulses per measurement
// (RL5) Results saturate at 256 times units minus one
// (RL6) Proximity conversion time follows the formula
// (RL7) Cycle is light, proximity, then wait time
// (RL8) Light persistence: zero every conversion, else count
// (RL9) Proximity persistence: zero every conversion, else count
// (RL10) Light data compared against low/high thresholds
// (RL11) Proximity data compared against low/high thresholds
// (RL12) Subtract crosstalk offset from raw proximity
// (RL13) Count consecutive hits, fire and restart
// (RL14) Clamp corrected proximity result at zero
// (RL15) Host writes low byte first, when idle
module pcf_prox_cfg
	import pcf_pkg::*;
#(
	parameter int unsigned TPS_BASE_CYC = PCF_TPS_BASE_CYC, // Fixed part of proximity time.
	parameter int unsigned TPS_RES_CYC = PCF_TPS_RES_CYC // Time per resolution step.
) (
	input wire logic mclk, // System clock, 100 MHz.
	input wire logic rst_b, // Synchronous reset, active low.
	input wire logic [7:0] reg_addr, // Register byte address.
	input wire logic [7:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe, one cycle.
	input wire logic reg_rd, // Read strobe, one cycle.
	output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd.
	input wire logic meas_enable, // Runs measurement cycles while high.
	input wire logic light_conv_done, // Light conversion finished, one cycle.
	input wire logic [15:0] light_sample, // Selected light channel data.
	input wire logic [31:0] wait_cycles, // Programmed wait time in clock cycles.
	input wire logic [15:0] prox_raw, // Raw proximity converter count.
	input wire logic [15:0] ir_raw, // Raw infrared converter count.
	output logic led_sink_output, // LED sink driver on.
	output logic [1:0] led_current_select, // Peak sink current code.
	output logic [1:0] proximity_gain_code, // Proximity analog gain code.
	output logic [15:0] proximity_result, // Offset-corrected proximity result.
	output logic [15:0] infrared_result, // Saturated infrared result.
	output logic result_valid, // New results stored, one cycle.
	output logic light_irq_event, // Light interrupt event, one cycle.
	output logic prox_irq_event // Proximity interrupt event, one cycle.
);

	pcf_state_s st; // Registered state.
	pcf_state_s next_st; // Next state.
	localparam pcf_state_s PCF_RST_STATE = '{
		led_drive: PCF_LED_DRIVE_RST,
		proximity_gain_code: PCF_GAIN_RST,
		led_pulse_number: PCF_PULSE_RST,
		proximity_resolution: PCF_TIME_RST,
		persist: PCF_PERSIST_RST,
		light_lo: PCF_THR_LO_RST,
		light_hi: PCF_THR_HI_RST,
		prox_lo: PCF_THR_LO_RST,
		prox_hi: PCF_THR_HI_RST,
		crosstalk_correction: PCF_OFFSET_RST,
		phase: PCF_PH_IDLE,
		default: '0
	};

	logic [31:0] tps_cyc; // Proximity conversion time in cycles.
	logic [16:0] width_cyc; // One LED pulse length in cycles.
	logic [15:0] sat_limit; // Saturation limit for the present resolution.
	logic [15:0] prox_sat; // Saturated raw proximity count.
	logic [15:0] prox_corr; // Offset-corrected proximity count.
	logic [15:0] ir_sat; // Saturated infrared count.

	// Derived timing. The product is kept in 32 bits; the largest setting
	// needs about 30 bits, so nothing is lost.
	always_comb begin
		tps_cyc = 32'(PCF_TPS_SCALE * (TPS_BASE_CYC
			+ (2 * int'(st.led_pulse_number) + 1)
			* (PCF_TPS_PULSE_CYC + PCF_TPS_WIDTH_CYC * int'(st.led_drive.led_pulse_width))
			+ TPS_RES_CYC * int'(st.proximity_resolution))); // [RL6]
		width_cyc = 17'((int'(st.led_drive.led_pulse_width) + 1) * PCF_PULSE_UNIT_CYC); // [RL2]
	end

	// Result conditioning: saturate to the resolution, then remove crosstalk.
	always_comb begin
		sat_limit = {PCF_SAT_PAD, st.proximity_resolution, PCF_SAT_LOW_BYTE}; // [RL5]
		prox_sat = (prox_raw > sat_limit) ? sat_limit : prox_raw; // [RL5]
		ir_sat = (ir_raw > sat_limit) ? sat_limit : ir_raw; // [RL5]
		// A large offset must not wrap the result round to a huge count.
		if (prox_sat > st.crosstalk_correction) begin
			prox_corr = prox_sat - st.crosstalk_correction; // [RL12]
		end else begin
			prox_corr = 16'h0000; // [RL14]
		end
	end

	// Register file, read port and measurement sequencer.
	always_comb begin
		next_st = st;
		next_st.result_valid = 1'b0;
		next_st.light_eval = 1'b0;
		next_st.prox_eval = 1'b0;

		// Writes land byte by byte; a 16-bit value is only coherent once the
		// host has written both halves, low byte first, while idle. [RL15]
		if (reg_wr) begin
			unique case (reg_addr)
				PCF_ADDR_LED_DRIVE: next_st.led_drive = reg_wdata; // [RL1] [RL2]
				PCF_ADDR_GAIN: next_st.proximity_gain_code = reg_wdata[1:0]; // [RL3]
				PCF_ADDR_PULSE: next_st.led_pulse_number = reg_wdata; // [RL4]
				PCF_ADDR_TIME: next_st.proximity_resolution = reg_wdata[3:0]; // [RL5]
				PCF_ADDR_PERSIST: next_st.persist = reg_wdata; // [RL8] [RL9]
				PCF_ADDR_LLO_L: next_st.light_lo[7:0] = reg_wdata; // [RL10]
				PCF_ADDR_LLO_H: next_st.light_lo[15:8] = reg_wdata; // [RL10]
				PCF_ADDR_LHI_L: next_st.light_hi[7:0] = reg_wdata; // [RL10]
				PCF_ADDR_LHI_H: next_st.light_hi[15:8] = reg_wdata; // [RL10]
				PCF_ADDR_PLO_L: next_st.prox_lo[7:0] = reg_wdata; // [RL11]
				PCF_ADDR_PLO_H: next_st.prox_lo[15:8] = reg_wdata; // [RL11]
				PCF_ADDR_PHI_L: next_st.prox_hi[7:0] = reg_wdata; // [RL11]
				PCF_ADDR_PHI_H: next_st.prox_hi[15:8] = reg_wdata; // [RL11]
				PCF_ADDR_OFF_L: next_st.crosstalk_correction[7:0] = reg_wdata; // [RL12]
				PCF_ADDR_OFF_H: next_st.crosstalk_correction[15:8] = reg_wdata; // [RL12]
				default: begin
					// Unmapped addresses ignore writes.
				end
			endcase
		end

		// Reads answer one cycle later; unmapped addresses read as zero.
		if (reg_rd) begin
			unique case (reg_addr)
				PCF_ADDR_LED_DRIVE: next_st.rdata = st.led_drive;
				PCF_ADDR_GAIN: next_st.rdata = {PCF_GAIN_PAD, st.proximity_gain_code}; // [RL3]
				PCF_ADDR_PULSE: next_st.rdata = st.led_pulse_number;
				PCF_ADDR_TIME: next_st.rdata = {PCF_TIME_PAD, st.proximity_resolution};
				PCF_ADDR_PERSIST: next_st.rdata = st.persist;
				PCF_ADDR_LLO_L: next_st.rdata = st.light_lo[7:0];
				PCF_ADDR_LLO_H: next_st.rdata = st.light_lo[15:8];
				PCF_ADDR_LHI_L: next_st.rdata = st.light_hi[7:0];
				PCF_ADDR_LHI_H: next_st.rdata = st.light_hi[15:8];
				PCF_ADDR_PLO_L: next_st.rdata = st.prox_lo[7:0];
				PCF_ADDR_PLO_H: next_st.rdata = st.prox_lo[15:8];
				PCF_ADDR_PHI_L: next_st.rdata = st.prox_hi[7:0];
				PCF_ADDR_PHI_H: next_st.rdata = st.prox_hi[15:8];
				PCF_ADDR_OFF_L: next_st.rdata = st.crosstalk_correction[7:0];
				PCF_ADDR_OFF_H: next_st.rdata = st.crosstalk_correction[15:8];
				default: next_st.rdata = PCF_READ_ZERO;
			endcase
		end

		// One measurement cycle: light conversion, proximity conversion, wait.
		unique case (st.phase)
			PCF_PH_IDLE: begin
				if (meas_enable) begin
					next_st.phase = PCF_PH_LIGHT; // [RL7]
				end
			end
			PCF_PH_LIGHT: begin
				// The light converter times itself; this block waits for it.
				if (light_conv_done) begin
					next_st.light_eval = 1'b1;
					next_st.light_hit = (light_sample > st.light_hi)
						|| (light_sample < st.light_lo); // [RL10]
					next_st.phase = PCF_PH_PROX; // [RL7]
					next_st.timer = tps_cyc - 32'h1; // [RL6]
					next_st.pulses_left = {1'b0, st.led_pulse_number} + 9'h001; // [RL4]
					next_st.pulse_timer = '0;
					next_st.led_on = 1'b0;
				end
			end
			PCF_PH_PROX: begin
				// LED pulses: on for one width, off for one width, repeated.
				if (st.pulse_timer != 17'h0) begin
					next_st.pulse_timer = st.pulse_timer - 17'h1;
				end else if (st.led_on) begin
					next_st.led_on = 1'b0;
					next_st.pulse_timer = width_cyc - 17'h1; // [RL2]
				end else if (st.pulses_left != 9'h0) begin
					next_st.led_on = 1'b1; // [RL4]
					next_st.pulse_timer = width_cyc - 17'h1; // [RL2]
					next_st.pulses_left = st.pulses_left - 9'h1;
				end
				if (st.timer == 32'h0) begin
					// End of conversion: the LED is forced off and results land.
					next_st.led_on = 1'b0;
					next_st.phase = PCF_PH_WAIT; // [RL7]
					next_st.timer = wait_cycles;
					next_st.proximity_result = prox_corr; // [RL12] [RL14]
					next_st.infrared_result = ir_sat; // [RL5]
					next_st.result_valid = 1'b1;
					next_st.prox_eval = 1'b1;
					next_st.prox_hit = (prox_corr > st.prox_hi)
						|| (prox_corr < st.prox_lo); // [RL11]
				end else begin
					next_st.timer = st.timer - 32'h1; // [RL6]
				end
			end
			PCF_PH_WAIT: begin
				// A zero wait still costs one cycle.
				if (st.timer <= 32'h1) begin
					next_st.phase = meas_enable ? PCF_PH_LIGHT : PCF_PH_IDLE; // [RL7]
				end else begin
					next_st.timer = st.timer - 32'h1;
				end
			end
		endcase
	end

	// Register the state.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st <= PCF_RST_STATE;
		end else begin
			st <= next_st;
		end
	end

	// Light and proximity persistence counters.
	pcf_persist u_light_persist (
		.mclk(mclk),
		.rst_b(rst_b),
		.sample(st.light_eval),
		.hit(st.light_hit),
		.setting(st.persist.light_persistence),
		.fire(light_irq_event)
	);
	pcf_persist u_prox_persist (
		.mclk(mclk),
		.rst_b(rst_b),
		.sample(st.prox_eval),
		.hit(st.prox_hit),
		.setting(st.persist.proximity_persistence),
		.fire(prox_irq_event)
	);

	assign reg_rdata = st.rdata;
	assign led_sink_output = st.led_on;
	assign led_current_select = st.led_drive.led_current_select;
	assign proximity_gain_code = st.proximity_gain_code;
	assign proximity_result = st.proximity_result;
	assign infrared_result = st.infrared_result;
	assign result_valid = st.result_valid;

	// Helper counters that only the checks below read.
	logic [16:0] on_len; // Cycles the LED has been on.
	logic [8:0] pulses_seen; // LED pulses in the present conversion.
	logic [31:0] prox_len; // Cycles spent in the proximity phase.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			on_len <= '0;
			pulses_seen <= '0;
			prox_len <= '0;
		end else begin
			on_len <= st.led_on ? on_len + 17'h1 : 17'h0;
			pulses_seen <= (st.phase != PCF_PH_PROX) ? 9'h0
				: pulses_seen + {8'h00, next_st.led_on && !st.led_on};
			prox_len <= (st.phase == PCF_PH_PROX) ? prox_len + 32'h1 : 32'h0;
		end
	end

	property p_current_write;
		@(posedge mclk) disable iff (!rst_b)
		reg_wr && reg_addr == PCF_ADDR_LED_DRIVE |=> led_current_select == $past(reg_wdata[7:6]);
	endproperty
	a_current_write: assert property (p_current_write) else $error("current select not taken"); // [RL1]

	property p_pulse_len;
		@(posedge mclk) disable iff (!rst_b)
		$fell(led_sink_output) && st.phase == PCF_PH_PROX |-> on_len == width_cyc;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("LED pulse length wrong"); // [RL2]

	property p_gain_pad;
		@(posedge mclk) disable iff (!rst_b)
		reg_rd && reg_addr == PCF_ADDR_GAIN |=> reg_rdata[7:2] == PCF_GAIN_PAD;
	endproperty
	a_gain_pad: assert property (p_gain_pad) else $error("gain upper bits not zero"); // [RL3]

	sequence s_prox_end;
		st.phase == PCF_PH_PROX ##1 st.phase == PCF_PH_WAIT;
	endsequence

	property p_pulse_count;
		@(posedge mclk) disable iff (!rst_b)
		s_prox_end |-> pulses_seen == {1'b0, st.led_pulse_number} + 9'h001;
	endproperty
	a_pulse_count: assert property (p_pulse_count) else $error("wrong number of LED pulses"); // [RL4]

	property p_saturate;
		@(posedge mclk) disable iff (!rst_b)
		result_valid |-> infrared_result <= sat_limit && proximity_result <= sat_limit;
	endproperty
	a_saturate: assert property (p_saturate) else $error("result above saturation limit"); // [RL5]

	property p_conv_time;
		@(posedge mclk) disable iff (!rst_b)
		s_prox_end |-> prox_len == tps_cyc;
	endproperty
	a_conv_time: assert property (p_conv_time) else $error("proximity time wrong"); // [RL6]

	property p_light_to_prox;
		@(posedge mclk) disable iff (!rst_b)
		st.phase == PCF_PH_LIGHT && light_conv_done |=> st.phase == PCF_PH_PROX && !led_sink_output;
	endproperty
	a_light_to_prox: assert property (p_light_to_prox) else $error("light phase did not end"); // [RL7]

	property p_light_high;
		@(posedge mclk) disable iff (!rst_b)
		st.phase == PCF_PH_LIGHT && light_conv_done && st.persist.light_persistence == 4'h1
			&& light_sample > st.light_hi |-> ##2 light_irq_event;
	endproperty
	a_light_high: assert property (p_light_high) else $error("light threshold missed"); // [RL10]

	property p_clamp;
		@(posedge mclk) disable iff (!rst_b)
		st.phase == PCF_PH_PROX && st.timer == 32'h0 && prox_raw <= st.crosstalk_correction
			|=> result_valid && proximity_result == 16'h0000;
	endproperty
	a_clamp: assert property (p_clamp) else $error("offset result not clamped"); // [RL14]

endmodule

// ==== pcf_host.sv ====
`timescale 1ns/100ps
// Host side of the register port, issuing one byte cycle at a time.
module pcf_host
	import pcf_pkg::*;
(
	input wire logic mclk, // System clock.
	output logic [7:0] reg_addr, // Register address.
	output logic [7:0] reg_wdata, // Write data.
	output logic reg_wr, // Write strobe.
	output logic reg_rd // Read strobe.
);
	// The port is quiet at time zero.
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One access: signals change after an edge and hold through the taking edge.
	task automatic cycle(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_wr = wr;
		reg_rd = rd;
		reg_addr = a;
		reg_wdata = d;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		// Released lines show the inverse, so a stale value never looks valid.
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// A 16-bit value goes low byte first, while measurement is off.
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		cycle(1'b1, 1'b0, a, v[7:0]);
		cycle(1'b1, 1'b0, a + 8'h01, v[15:8]);
	endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/100ps
// Register map checks first, then three measurement cycles with queued notes.
module testbench;
	import pcf_pkg::*;
	localparam int unsigned TB = 50; // Shortened fixed part of the proximity time.
	localparam int unsigned TR = 10; // Shortened time per resolution step.
	localparam logic [15:0] OFS = 16'h0010; // Crosstalk offset for the run.
	// One note per measurement cycle.
	typedef struct packed {
		logic [15:0] prox;
		logic [15:0] ir;
		logic light_ev;
		logic prox_ev;
		logic [31:0] dur;
	} pcf_tb_exp_s;
	logic mclk, rst_b, reg_wr, reg_rd, meas_enable, light_conv_done;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [15:0] light_sample, prox_raw, ir_raw, p_res, i_res, s;
	logic led, rv, lev, pev, pend, pchk, pexp, lseen, led_prev;
	logic [1:0] cur, gain, cs, g;
	logic [3:0] r;
	logic [7:0] d;
	int n_fail, n_compared, i, m, k, cyc, t0, led_cnt, led_rise;
	logic [7:0] rd_q[$];
	pcf_tb_exp_s m_q[$];
	pcf_tb_exp_s e, en;
	// Map: the fifth entry is the unmapped hole at 0x0A.
	logic [7:0] adr [16] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
		8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
	logic [7:0] rst [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00,
		8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
	logic [7:0] msk [16] = '{8'hFF, 8'h03, 8'hFF, 8'h0F, 8'h00, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	// Light samples all leave the window; proximity raws give in, out, in.
	logic [15:0] ls [3] = '{16'h9000, 16'h0010, 16'hC000};
	logic [15:0] pr [3] = '{16'hF000, 16'h0008, 16'h0040};

	pcf_prox_cfg #(.TPS_BASE_CYC(TB), .TPS_RES_CYC(TR)) dut_u (.mclk(mclk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .meas_enable(meas_enable), .light_conv_done(light_conv_done),
		.light_sample(light_sample), .wait_cycles(32'h00000014), .prox_raw(prox_raw),
		.ir_raw(ir_raw), .led_sink_output(led), .led_current_select(cur),
		.proximity_gain_code(gain), .proximity_result(p_res), .infrared_result(i_res),
		.result_valid(rv), .light_irq_event(lev), .prox_irq_event(pev));
	pcf_host host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd));

	// Saturation at 256 times the unit count minus one.
	function automatic logic [15:0] sat(input logic [15:0] v, input logic [3:0] rr);
		logic [15:0] lim;
		lim = {4'h0, rr, 8'hFF};
		return (v > lim) ? lim : v;
	endfunction
	// Counted comparison; four-state inequality so unknowns fail.
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
		n_compared++;
		if (y !== x) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, x, y);
		end
	endtask
	// Single place where the run ends.
	task automatic stop_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Cuts a hang short; a normal run needs about 0.6 ms.
	initial begin
		#800000;
		n_fail++;
		stop_test();
	end
	// Watcher on the falling edge, where registered outputs are settled.
	always @(negedge mclk) begin
		cyc++;
		if (pend) chk("reg_rdata", rd_q.pop_front(), reg_rdata);
		pend = reg_rd;
		if (pchk) chk("prox_irq_event", pexp, pev);
		pchk = 1'b0;
		if (light_conv_done) begin
			t0 = cyc;
			led_cnt = 0;
			led_rise = 0;
			lseen = 1'b0;
		end
		if (led) led_cnt++;
		if (led && !led_prev) begin
			led_rise++;
			if (led_rise == 1) chk("led start", 2, cyc - t0);
		end
		led_prev = led;
		if (lev) begin
			lseen = 1'b1;
			chk("light event delay", 2, cyc - t0);
		end
		if (rv) begin
			e = m_q.pop_front();
			chk("proximity_result", e.prox, p_res);
			chk("infrared_result", e.ir, i_res);
			chk("conversion cycles", e.dur, cyc - t0);
			chk("led on cycles", 1367, led_cnt);
			chk("led pulses", 1, led_rise);
			chk("light_irq_event", e.light_ev, lseen);
			pexp = e.prox_ev;
			pchk = 1'b1;
		end
	end
	// Main sequence: reset, map, configuration, then three measurements.
	initial begin
		{rst_b, meas_enable, light_conv_done, pend, pchk, led_prev} = 6'h00;
		{light_sample, prox_raw, ir_raw} = 48'h0;
		{n_fail, n_compared, cyc, t0} = '0;
		void'($urandom(73));
		repeat (3) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		for (i = 0; i < 16; i++) begin
			rd_q.push_back(rst[i]);
			host_u.cycle(1'b0, 1'b1, adr[i], 8'h00);
		end
		for (i = 0; i < 16; i++) begin
			d = 8'($urandom);
			host_u.cycle(1'b1, 1'b0, adr[i], d);
			rd_q.push_back(d & msk[i]);
			host_u.cycle(1'b0, 1'b1, adr[i], 8'h00);
		end
		cs = 2'($urandom);
		g = 2'($urandom);
		r = 4'($urandom);
		host_u.cycle(1'b1, 1'b0, 8'h06, {cs, 6'h00});
		host_u.cycle(1'b1, 1'b0, 8'h07, {6'h3F, g});
		host_u.cycle(1'b1, 1'b0, 8'h08, 8'h00);
		host_u.cycle(1'b1, 1'b0, 8'h09, {4'h0, r});
		host_u.cycle(1'b1, 1'b0, 8'h0B, 8'h12);
		host_u.wr16(8'h0C, 16'h0100);
		host_u.wr16(8'h0E, 16'h8000);
		host_u.wr16(8'h10, 16'h0005);
		host_u.wr16(8'h12, 16'hFFF0);
		host_u.wr16(8'h14, OFS);
		chk("led_current_select", cs, cur);
		chk("proximity_gain_code", g, gain);
		meas_enable = 1'b1;
		for (m = 0; m < 3; m++) begin
			light_sample = ls[m];
			prox_raw = pr[m];
			ir_raw = 16'($urandom);
			s = sat(pr[m], r);
			en.prox = (s > OFS) ? s - OFS : 16'h0000;
			en.ir = sat(ir_raw, r);
			en.light_ev = (m >= 1);
			en.prox_ev = (m >= 1);
			en.dur = 32'(16 * (TB + 1000 + TR * r) + 1);
			m_q.push_back(en);
			// Last cycle: light persistence one, proximity zero (fires on every conversion).
			if (m == 2) host_u.cycle(1'b1, 1'b0, 8'h0B, 8'h01);
			repeat (30) @(posedge mclk);
			#1;
			light_conv_done = 1'b1;
			@(posedge mclk);
			#1;
			light_conv_done = 1'b0;
			for (k = 0; k < 40000 && rv !== 1'b1; k++) @(negedge mclk);
			// A conversion that never ends must not slip through to a pass.
			if (rv !== 1'b1) n_fail++;
			@(posedge mclk);
			#1;
		end
		meas_enable = 1'b0;
		repeat (5) @(posedge mclk);
		stop_test();
	end
endmodule
